// [oae_dec_if.sv]
`timescale 1ns/1ps
interface oae_dec_if;
    logic [11:0] instr;
    oae_pkg::oae_op_t op;
    logic dest;
    logic [4:0] addr;
    logic [7:0] literal;

    modport dec
    (
        input instr,
        output op,
        output dest,
        output addr,
        output literal
    );
    modport exec
    (
        output instr,
        input op,
        input dest,
        input addr,
        input literal
    );
endinterface

// [oae_decode.sv]
`timescale 1ns/1ps
module oae_decode
(
    oae_dec_if.dec dec_if
);
    wire [3:0] top4;
    wire [5:0] top6;
    wire is_lit_or;
    wire is_file_or;
    wire is_move;

    assign top4 = dec_if.instr[oae_pkg::OAE_INSTR_MSB -: 4];
    assign top6 = dec_if.instr[oae_pkg::OAE_INSTR_MSB -: 6];
    assign is_lit_or = (top4 == oae_pkg::OAE_OPC_LIT_OR);
    assign is_file_or = (top6 == oae_pkg::OAE_OPC_FILE_OR);
    assign is_move = (top6 == oae_pkg::OAE_OPC_MOVE);

    assign dec_if.op = is_lit_or ? oae_pkg::OAE_OP_LIT_OR :
                       is_file_or ? oae_pkg::OAE_OP_FILE_OR :
                       is_move ? oae_pkg::OAE_OP_MOVE : oae_pkg::OAE_OP_NONE;
    assign dec_if.dest = dec_if.instr[oae_pkg::OAE_DEST_BIT];
    // full 5-bit field used as the address, no banking
    assign dec_if.addr = dec_if.instr[oae_pkg::OAE_ADDR_MSB:0];
    assign dec_if.literal = dec_if.instr[oae_pkg::OAE_LIT_MSB:0];
endmodule // oae_decode

// [oae_exec.sv]
// Operation
// - A word whose top four bits are 1101 is the literal-OR, with the low byte as literal.
// - Literal-OR puts the working register ORed with the literal into the working register.
// - Literal-OR sets the zero flag when its result is zero and clears it otherwise.
// - A word 0001 00df ffff is the register-OR, bit 5 the destination, low five bits the address.
// - Register-OR writes acc OR file to acc when the destination bit is 0, else to the file.
// - Register-OR sets zero from its result whichever destination is chosen.
// - A word 0010 00df ffff is the register-move, passing the file value unchanged.
// - Move with destination 0 loads the file value into acc and leaves the file alone.
// - Move with destination 1 writes the value back to the same file and leaves acc alone.
// - Move sets zero from the moved value for either destination.
`timescale 1ns/1ps
module oae_exec
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire logic [11:0] instr_in,
    input wire logic [4:0] file_peek_addr_in,
    output logic [7:0] acc_out,
    output logic zero_flag_out,
    output logic done_out,
    output logic unsupported_out,
    output logic [7:0] file_peek_data_out
);
    oae_dec_if dec_if();

    logic [7:0] file_mem [0:31];
    logic [7:0] acc_reg;
    logic zero_reg;
    logic done_reg;
    logic unsupported_reg;
    logic [7:0] peek_reg;

    wire [7:0] rd_val;
    wire [7:0] alu_res;
    wire exec_go;
    wire acc_wr;
    wire file_wr;
    wire is_lit;
    wire is_or_file;

    assign dec_if.instr = instr_in;

    oae_decode u_decode
    (
        .dec_if(dec_if)
    );

    assign is_lit = (dec_if.op == oae_pkg::OAE_OP_LIT_OR);
    assign is_or_file = (dec_if.op == oae_pkg::OAE_OP_FILE_OR);
    assign rd_val = file_mem[dec_if.addr];
    assign alu_res = is_lit ? (acc_reg | dec_if.literal) :
                     is_or_file ? (acc_reg | rd_val) :
                     rd_val;
    // words outside the three decoded here leave acc, zero flag and file alone; only the unsupported flag is raised
    assign exec_go = instr_valid_in && (dec_if.op != oae_pkg::OAE_OP_NONE);
    assign acc_wr = exec_go && (is_lit || !dec_if.dest);
    assign file_wr = exec_go && !is_lit && dec_if.dest;

    genvar gi;
    generate
        for (gi = 0; gi < oae_pkg::OAE_NUM_FILE; gi++)
        begin : g_file
            always_ff @(posedge sys_clk_in or posedge rst_in)
            begin
                if (rst_in)
                    file_mem[gi] <= oae_pkg::OAE_FILE_RST;
                else if (file_wr && (dec_if.addr == 5'(gi)))
                    file_mem[gi] <= alu_res;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc_reg <= oae_pkg::OAE_ACC_RST;
            zero_reg <= oae_pkg::OAE_ZERO_RST;
            done_reg <= 1'b0;
            unsupported_reg <= 1'b0;
            peek_reg <= oae_pkg::OAE_FILE_RST;
        end
        else
        begin
            if (acc_wr)
                acc_reg <= alu_res;
            if (exec_go)
                zero_reg <= (alu_res == oae_pkg::OAE_ZERO_BYTE);
            done_reg <= exec_go;
            unsupported_reg <= instr_valid_in && !exec_go;
            // peek shows the array after this edge's write only one cycle later
            peek_reg <= file_mem[file_peek_addr_in];
        end
    end

    assign acc_out = acc_reg;
    assign zero_flag_out = zero_reg;
    assign done_out = done_reg;
    assign unsupported_out = unsupported_reg;
    assign file_peek_data_out = peek_reg;

    wire lit_go;
    wire or_go;
    wire mov_go;
    assign lit_go = exec_go && is_lit;
    assign or_go = exec_go && is_or_file;
    assign mov_go = exec_go && (dec_if.op == oae_pkg::OAE_OP_MOVE);

    property p_lit_or_acc;
        @(posedge sys_clk_in) disable iff (rst_in)
        lit_go |=> acc_reg == ($past(acc_reg) | $past(dec_if.literal));
    endproperty
    a_lit_or_acc: assert property (p_lit_or_acc) else $error("literal OR result wrong");

    property p_lit_or_zero;
        @(posedge sys_clk_in) disable iff (rst_in)
        lit_go |=> zero_reg == (acc_reg == 8'h00);
    endproperty
    a_lit_or_zero: assert property (p_lit_or_zero) else $error("literal OR zero flag wrong");

    property p_lit_decode;
        @(posedge sys_clk_in) disable iff (rst_in)
        instr_valid_in && (instr_in[11:8] == 4'hd) |-> lit_go;
    endproperty
    a_lit_decode: assert property (p_lit_decode) else $error("literal OR not decoded");

    property p_or_to_acc;
        @(posedge sys_clk_in) disable iff (rst_in)
        or_go && !dec_if.dest |=> acc_reg == ($past(acc_reg) | $past(rd_val));
    endproperty
    a_or_to_acc: assert property (p_or_to_acc) else $error("register OR to acc wrong");

    property p_or_to_file;
        @(posedge sys_clk_in) disable iff (rst_in)
        or_go && dec_if.dest |=> file_mem[$past(dec_if.addr)] == ($past(acc_reg) | $past(rd_val))
            && acc_reg == $past(acc_reg) && zero_reg == (file_mem[$past(dec_if.addr)] == 8'h00);
    endproperty
    a_or_to_file: assert property (p_or_to_file) else $error("register OR to file wrong");

    property p_move_to_acc;
        @(posedge sys_clk_in) disable iff (rst_in)
        mov_go && !dec_if.dest |=> acc_reg == $past(rd_val)
            && file_mem[$past(dec_if.addr)] == $past(rd_val);
    endproperty
    a_move_to_acc: assert property (p_move_to_acc) else $error("move to acc wrong");

    property p_move_to_file;
        @(posedge sys_clk_in) disable iff (rst_in)
        mov_go && dec_if.dest |=> acc_reg == $past(acc_reg)
            && file_mem[$past(dec_if.addr)] == $past(rd_val);
    endproperty
    a_move_to_file: assert property (p_move_to_file) else $error("move to file wrong");

    property p_move_zero;
        @(posedge sys_clk_in) disable iff (rst_in)
        mov_go |=> zero_reg == ($past(rd_val) == 8'h00);
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("move zero flag wrong");

    property p_one_cycle;
        @(posedge sys_clk_in) disable iff (rst_in)
        exec_go |=> done_reg ##1 (done_reg == $past(exec_go));
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("operation not done in one cycle");

    property p_other_untouched;
        @(posedge sys_clk_in) disable iff (rst_in)
        !exec_go |=> $stable(zero_reg) && $stable(acc_reg);
    endproperty
    a_other_untouched: assert property (p_other_untouched) else $error("idle cycle changed state");

    property p_or_decode;
        @(posedge sys_clk_in) disable iff (rst_in)
        instr_valid_in && (instr_in[11:6] == 6'h04) |-> or_go;
    endproperty
    a_or_decode: assert property (p_or_decode) else $error("register OR not decoded");

    property p_move_decode;
        @(posedge sys_clk_in) disable iff (rst_in)
        instr_valid_in && (instr_in[11:6] == 6'h08) |-> mov_go;
    endproperty
    a_move_decode: assert property (p_move_decode) else $error("move not decoded");

    property p_or_zero_acc;
        @(posedge sys_clk_in) disable iff (rst_in)
        or_go && !dec_if.dest |=> zero_reg == (acc_reg == 8'h00);
    endproperty
    a_or_zero_acc: assert property (p_or_zero_acc) else $error("OR zero flag wrong");

    property p_lit_file;
        @(posedge sys_clk_in) disable iff (rst_in)
        lit_go |=> file_mem[$past(dec_if.addr)] == $past(rd_val);
    endproperty
    a_lit_file: assert property (p_lit_file) else $error("file hit by literal OR");

    property p_or_acc_file;
        @(posedge sys_clk_in) disable iff (rst_in)
        or_go && !dec_if.dest |=> file_mem[$past(dec_if.addr)] == $past(rd_val);
    endproperty
    a_or_acc_file: assert property (p_or_acc_file) else $error("OR to acc hit file");

    property p_refused;
        @(posedge sys_clk_in) disable iff (rst_in)
        instr_valid_in && !exec_go |=> unsupported_reg && !done_reg
            && $stable(acc_reg) && $stable(zero_reg);
    endproperty
    a_refused: assert property (p_refused) else $error("refused word changed state");

    property p_done_pulse;
        @(posedge sys_clk_in) disable iff (rst_in)
        !exec_go |=> !done_reg;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done without a word");

    property p_peek;
        @(posedge sys_clk_in) disable iff (rst_in)
        1'b1 |=> peek_reg == $past(file_mem[file_peek_addr_in]);
    endproperty
    a_peek: assert property (p_peek) else $error("peek data wrong");
endmodule // oae_exec

// [oae_pkg.sv]
package oae_pkg;
    localparam int OAE_DATA_W = 8;
    localparam int OAE_INSTR_W = 12;
    localparam int OAE_ADDR_W = 5;
    localparam int OAE_NUM_FILE = 32;
    // field positions inside the instruction word
    localparam int OAE_INSTR_MSB = 11;
    localparam int OAE_DEST_BIT = 5;
    localparam int OAE_ADDR_MSB = 4;
    localparam int OAE_LIT_MSB = 7;
    // opcode patterns: 1101 kkkk kkkk, 0001 00df ffff, 0010 00df ffff
    localparam logic [3:0] OAE_OPC_LIT_OR = 4'hd;
    localparam logic [5:0] OAE_OPC_FILE_OR = 6'h04;
    localparam logic [5:0] OAE_OPC_MOVE = 6'h08;
    // reset values, and the byte that the zero flag compares against
    localparam logic [7:0] OAE_ACC_RST = 8'h00;
    localparam logic [7:0] OAE_FILE_RST = 8'h00;
    localparam logic OAE_ZERO_RST = 1'b0;
    localparam logic [7:0] OAE_ZERO_BYTE = 8'h00;

    typedef enum logic [1:0] {
        OAE_OP_NONE = 2'b00,
        OAE_OP_LIT_OR = 2'b01,
        OAE_OP_FILE_OR = 2'b10,
        OAE_OP_MOVE = 2'b11
    } oae_op_t;
endpackage

// [or_and_move_instruction_exec_tb.sv]
`timescale 1ns/1ps
module or_and_move_instruction_exec_tb;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic instr_valid_in = 1'b0;
    logic [11:0] instr_in = 12'h000;
    logic [4:0] file_peek_addr_in = 5'h00;
    logic [7:0] acc_out, file_peek_data_out, acc_m, peek_m;
    logic zero_flag_out, done_out, unsupported_out, zero_m, done_m, unsup_m;
    logic [7:0] file_m [32];
    int miscompares = 0;
    int checks_done = 0;
    int seed = 32'hee6d;
    logic [31:0] r;
    always #5 sys_clk_in = ~sys_clk_in;
    oae_exec i_oae_exec (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in),
        .file_peek_addr_in(file_peek_addr_in), .acc_out(acc_out),
        .zero_flag_out(zero_flag_out), .done_out(done_out),
        .unsupported_out(unsupported_out), .file_peek_data_out(file_peek_data_out));
    // 1 literal or, 2 file or, 3 move, 0 anything else
    function automatic logic [1:0] kind_of(input logic [11:0] w);
        if (w[11:8] == 4'hd) return 2'h1;
        if (w[11:6] == 6'h04) return 2'h2;
        if (w[11:6] == 6'h08) return 2'h3;
        return 2'h0;
    endfunction
    // reference model, reads inputs before this edge's stimulus lands
    always @(posedge sys_clk_in or posedge rst_in)
    begin : model
        logic [7:0] res;
        logic [1:0] k;
        if (rst_in)
        begin
            {acc_m, zero_m, done_m, unsup_m, peek_m} = 19'h00000;
            for (int i = 0; i < 32; i++) file_m[i] = 8'h00;
        end
        else
        begin
            peek_m = file_m[file_peek_addr_in];
            k = kind_of(instr_in);
            done_m = instr_valid_in && k != 2'h0;
            unsup_m = instr_valid_in && k == 2'h0;
            res = k == 2'h1 ? acc_m | instr_in[7:0] :
                  k == 2'h2 ? acc_m | file_m[instr_in[4:0]] : file_m[instr_in[4:0]];
            if (done_m)
            begin
                zero_m = res == 8'h00;
                if (k != 2'h1 && instr_in[5]) file_m[instr_in[4:0]] = res;
                else acc_m = res;
            end
        end
    end
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // outputs settled well clear of both edges
    always @(negedge sys_clk_in)
    begin
        if (!rst_in)
        begin
            chk("done", {7'h00, done_m}, {7'h00, done_out});
            chk("unsupported", {7'h00, unsup_m}, {7'h00, unsupported_out});
            chk("acc", acc_m, acc_out);
            chk("zero", {7'h00, zero_m}, {7'h00, zero_flag_out});
            chk("peek", peek_m, file_peek_data_out);
        end
    end
    task issue(input logic v, input logic [11:0] w, input logic [4:0] pa);
        @(posedge sys_clk_in);
        instr_valid_in <= v;
        instr_in <= w;
        file_peek_addr_in <= pa;
    endtask
    task do_reset();
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        instr_valid_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
    endtask
    task test_done();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        // hang guard, far beyond the few thousand cycles the tests need
        #200000;
        miscompares++;
        $display("unexpected timeout: expected finish, seen hang");
        test_done();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        issue(1'b1, 12'hd00, 5'h00);
        issue(1'b1, 12'h200, 5'h00);
        issue(1'b1, 12'hd9a, 5'h00);
        issue(1'b1, 12'hd35, 5'h1f);
        issue(1'b1, 12'h13f, 5'h1f);
        issue(1'b1, 12'h23f, 5'h1f);
        issue(1'b1, 12'h11f, 5'h1f);
        issue(1'b1, 12'h200, 5'h1f);
        issue(1'b1, 12'h21f, 5'h00);
        r = $random(seed);
        foreach (file_m[i]) issue(1'b1, {6'h04, r[i], 5'(i)}, 5'(i));
        issue(1'b1, 12'h0c0, 5'h00);
        issue(1'b1, 12'h140, 5'h00);
        issue(1'b1, 12'h240, 5'h00);
        issue(1'b1, 12'hc55, 5'h00);
        issue(1'b1, 12'hfff, 5'h00);
        issue(1'b0, 12'hd01, 5'h00);
        $display("corner test done");
        do_reset();
        for (int n = 0; n < 3000; n++)
        begin
            r = $random(seed);
            case (r[13:12])
                2'h0: issue(r[31] | r[30], {4'hd, r[7:0]}, r[20:16]);
                2'h1: issue(r[31] | r[30], {6'h04, r[5:0]}, r[20:16]);
                2'h2: issue(r[31] | r[30], {6'h08, r[5:0]}, r[20:16]);
                default: issue(r[31] | r[30], r[11:0], r[20:16]);
            endcase
            if (n == 1500) do_reset();
        end
        for (int i = 0; i < 32; i++) issue(1'b0, 12'h000, 5'(i));
        issue(1'b0, 12'h000, 5'h00);
        issue(1'b0, 12'h000, 5'h00);
        $display("random test done");
        test_done();
    end
endmodule // or_and_move_instruction_exec_tb
